// file: hw/ssa_pkg.sv
// Shared constants for the synchronous serial byte adapter.
// Assumes a single 200 MHz system clock; the link clocks are sampled pins.
package ssa_pkg;

  // Word index on the Avalon bus, standing in for the register select line
  localparam logic       ADDR_CTL_STAT = 1'h0;
  localparam logic       ADDR_DATA     = 1'h1;

  // Target of a write to the data address, picked by two control-one bits
  localparam logic [1:0] SEL_CTL2      = 2'h0;
  localparam logic [1:0] SEL_CTL3      = 2'h1;
  localparam logic [1:0] SEL_SYNC      = 2'h2;
  localparam logic [1:0] SEL_TXDATA    = 2'h3;

  // Control register one
  localparam int C1_RX_HOLD  = 0;
  localparam int C1_TX_HOLD  = 1;
  localparam int C1_STRIP    = 2;
  localparam int C1_CLR_SYNC = 3;
  localparam int C1_TIE      = 4;
  localparam int C1_RIE      = 5;
  localparam int C1_SEL_LO   = 6;
  localparam int C1_SEL_HI   = 7;
  // Control register two
  localparam int C2_PC_ONE   = 0;
  localparam int C2_PC_TWO   = 1;
  localparam int C2_TWO_BYTE = 2;
  localparam int C2_EIE      = 6;
  // Control register three
  localparam int C3_EXT_SYNC = 0;
  localparam int C3_ONE_SYNC = 1;
  localparam int C3_UF_SYNC  = 3;
  // Status register
  localparam int ST_RDA      = 0;
  localparam int ST_TX_FIFO_SPACE_FLAG     = 1;
  localparam int ST_DCD      = 2;
  localparam int ST_SYNC     = 3;
  localparam int ST_UNDERRUN = 4;
  localparam int ST_OVERRUN  = 5;

  localparam logic [7:0] CTL1_RESET  = 8'h03;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] FILL_ONES   = 8'hFF;
  localparam logic [2:0] LAST_BIT    = 3'h7;

  // Pin synchroniser lanes
  localparam int PIN_TXCLK = 0;
  localparam int PIN_RXCLK = 1;
  localparam int PIN_RXD   = 2;
  localparam int PIN_DCD_N = 3;
  localparam int PIN_HRST  = 4;
  localparam int PIN_COUNT = 5;

  typedef enum logic [1:0] {
    SSA_TX_IDLE = 2'b00,
    SSA_TX_ARM  = 2'b01,
    SSA_TX_RUN  = 2'b10
  } ssa_tx_state_t;

  typedef enum logic [1:0] {
    SSA_RX_HUNT   = 2'b00,
    SSA_RX_SECOND = 2'b01,
    SSA_RX_SYNCED = 2'b10
  } ssa_rx_state_t;

endpackage : ssa_pkg

// file: hw/ssa_pin_sync.sv
// Two-flop synchronisers with edge detection for a group of pins.
// Assumes each pin is slow next to sys_clk_i (link clocks near 12.5 MHz).
`timescale 1ns/10ps
module ssa_pin_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;
  logic             primed_q;

  // Chain tracks the pins through reset, so no false edge follows it
  always_ff @(posedge sys_clk_i) begin
    meta_q <= pin_i;
    sync_q <= meta_q;
    last_q <= sync_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q & {WIDTH{primed_q}};
  assign fall_o  = ~sync_q & last_q & {WIDTH{primed_q}};

endmodule : ssa_pin_sync

// file: hw/ssa_top.sv
// Synchronous serial byte adapter: Avalon-MM slave, three-deep FIFOs, serial side.
// Assumes link clocks and pins are asynchronous and much slower than sys_clk_i.
`timescale 1ns/10ps
// How it works
// RULE1: Two bus words reach seven registers; status and receive data read-only, rest write-only.
// RULE2: Transmit FIFO three bytes deep; bytes move to last empty slot; space flag reported.
// RULE3: Bytes advance one FIFO slot per bus phase clock.
// RULE4: Single-byte mode flags one slot; two-byte mode flags two free or full slots.
// RULE5: Last FIFO slot loads the shifter in the second half of the last bit.
// RULE6: Characters leave the serial output least significant bit first.
// RULE7: On underflow send all ones or the sync code, per control bit.
// RULE8: Software leaves parity off; the transmitter never appends any.
// RULE9: Releasing transmitter hold waits for a full high phase, first bit on its fall.
// RULE10: An empty FIFO at start sends a fill character first.
// RULE11: Setting transmitter hold empties the FIFO; a clock later it accepts, flag inhibited.
// RULE12: External sync mode uses carrier detect, then passes every byte on.
// RULE13: Single-sync mode passes nothing until one character matches the sync code.
// RULE14: Two-sync mode needs two consecutive sync characters before locking.
// RULE15: Once locked, characters are assembled and data-available status is shown.
// RULE16: System reset latches an internal reset holding outputs quiet.
// RULE17: Software loads sync code and controls two and three before releasing holds.
// RULE18: Codec use: eight bits, no parity, external sync; terminal ready picks direction.
// RULE19: Hardware reset low sets holds, clears control bits, internal sync, flag.
// RULE20: Register select high reaches controls two, three, sync, data; low control one, status.
// RULE21: Transmit shifts on falling transmit clock; receive samples on rising receive clock.
module ssa_top
  import ssa_pkg::*;
#(
  parameter int DEPTH = 3
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [0:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        hw_reset_n_i,
  input  wire logic        tx_clk_i,
  input  wire logic        rx_clk_i,
  input  wire logic        rx_data_i,
  input  wire logic        carrier_detect_n_i,
  output logic             tx_data_o,
  output logic             terminal_ready_n_o,
  output logic             periph_ctl_two_o
);

  logic [PIN_COUNT-1:0] pin_lvl;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;

  ssa_pin_sync #(
    .WIDTH (PIN_COUNT)
  ) u_pins (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({hw_reset_n_i, carrier_detect_n_i, rx_data_i, rx_clk_i, tx_clk_i}),
    .level_o   (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  logic hw_rst;
  logic carrier;
  assign hw_rst  = ~pin_lvl[PIN_HRST];
  assign carrier = ~pin_lvl[PIN_DCD_N];

  // Bus slave: one wait cycle, then a single-cycle acceptance
  logic        wait_q;
  logic        acc_rd;
  logic        acc_wr;
  logic [7:0]  wbyte;
  logic        wr_ctl1;
  logic        wr_data;
  logic        rd_status;
  logic        rd_data;
  logic [7:0]  ctl1_q;
  logic [7:0]  ctl2_q;
  logic [7:0]  ctl3_q;
  logic [7:0]  sync_code_q;
  logic [7:0]  status;
  logic [31:0] rdata_q;

  assign acc_rd    = avs_read_i & ~wait_q;
  assign acc_wr    = avs_write_i & ~wait_q & avs_byteenable_i[0];
  assign wbyte     = avs_writedata_i[7:0];
  assign wr_ctl1   = acc_wr & (avs_address_i == ADDR_CTL_STAT); // RULE20
  assign wr_data   = acc_wr & (avs_address_i == ADDR_DATA); // RULE20
  assign rd_status = acc_rd & (avs_address_i == ADDR_CTL_STAT);
  assign rd_data   = acc_rd & (avs_address_i == ADDR_DATA);

  function automatic logic data_sel(input logic [7:0] c1, input logic [1:0] sel);
    data_sel = (c1[C1_SEL_HI:C1_SEL_LO] == sel);
  endfunction : data_sel

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
    end
  end

  // Control registers; reset-owned bits are frozen while the pin holds reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctl1_q      <= CTL1_RESET; // RULE16
      ctl2_q      <= REG_RESET;
      ctl3_q      <= REG_RESET;
      sync_code_q <= REG_RESET;
    end else begin
      if (wr_ctl1) begin
        ctl1_q <= wbyte; // RULE1
      end
      if (wr_data && data_sel(ctl1_q, SEL_CTL2)) begin
        ctl2_q <= wbyte;
      end
      if (wr_data && data_sel(ctl1_q, SEL_CTL3)) begin
        ctl3_q <= wbyte;
      end
      if (wr_data && data_sel(ctl1_q, SEL_SYNC)) begin
        sync_code_q <= wbyte;
      end
      if (hw_rst) begin
        ctl1_q[C1_RX_HOLD]  <= 1'b1; // RULE19
        ctl1_q[C1_TX_HOLD]  <= 1'b1; // RULE19
        ctl2_q[C2_PC_ONE]   <= 1'b0; // RULE19
        ctl2_q[C2_PC_TWO]   <= 1'b0; // RULE19
        ctl2_q[C2_EIE]      <= 1'b0; // RULE19
        ctl3_q[C3_EXT_SYNC] <= 1'b0; // RULE19
      end
    end
  end

  logic tx_hold;
  logic rx_hold;
  logic two_byte;
  logic tx_hold_dly_q;
  logic tx_clr;
  assign tx_hold  = ctl1_q[C1_TX_HOLD];
  assign rx_hold  = ctl1_q[C1_RX_HOLD];
  assign two_byte = ctl2_q[C2_TWO_BYTE];
  assign tx_clr   = tx_hold & ~tx_hold_dly_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_hold_dly_q <= 1'b0;
    end else begin
      tx_hold_dly_q <= tx_hold;
    end
  end

  // Transmit FIFO: slot 0 is the input, slot DEPTH-1 feeds the shifter
  logic [7:0]       txf_q [DEPTH];
  logic [7:0]       txf_d [DEPTH];
  logic [DEPTH-1:0] txv_q;
  logic [DEPTH-1:0] txv_d;
  logic             tx_pull;
  logic             tx_push;
  logic             tx_fifo_space_flag;
  assign tx_push = wr_data & data_sel(ctl1_q, SEL_TXDATA);
  // Flag gated by hold; the FIFO itself still accepts after the clear cycle
  assign tx_fifo_space_flag = ~tx_hold & (two_byte ? ~txv_q[0] & ~txv_q[1] : ~txv_q[0]); // RULE4 RULE11

  always_comb begin
    txf_d = txf_q;
    txv_d = txv_q;
    if (tx_pull) begin
      txv_d[DEPTH-1] = 1'b0;
    end
    for (int i = DEPTH - 1; i > 0; i--) begin
      if (!txv_d[i] && txv_d[i-1]) begin
        txf_d[i]   = txf_d[i-1]; // RULE2 RULE3
        txv_d[i]   = 1'b1;
        txv_d[i-1] = 1'b0;
      end
    end
    if (tx_push && !txv_d[0]) begin
      txf_d[0] = wbyte;
      txv_d[0] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || tx_clr) begin
      txv_q <= '0; // RULE11
    end else begin
      txv_q <= txv_d;
    end
    txf_q <= txf_d;
  end

  // Transmit shifter, driven by edges of the sampled transmit clock
  ssa_tx_state_t tx_state_q;
  logic [7:0]    tx_sr_q;
  logic [7:0]    tx_next_q;
  logic [2:0]    tx_idx_q;
  logic          tx_rise;
  logic          tx_fall;
  logic          tx_load;
  logic          underrun_q;
  logic [7:0]    fill;
  assign tx_rise = pin_rise[PIN_TXCLK];
  assign tx_fall = pin_fall[PIN_TXCLK];
  assign tx_load = tx_rise && ((tx_state_q == SSA_TX_ARM) ||
                   ((tx_state_q == SSA_TX_RUN) && (tx_idx_q == LAST_BIT))); // RULE5
  assign tx_pull = tx_load & txv_q[DEPTH-1];
  assign fill    = ctl3_q[C3_UF_SYNC] ? sync_code_q : FILL_ONES; // RULE7

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || tx_hold) begin
      tx_state_q <= SSA_TX_IDLE;
      tx_data_o  <= 1'b1; // RULE16
      tx_sr_q    <= FILL_ONES;
      tx_next_q  <= FILL_ONES;
      tx_idx_q   <= LAST_BIT;
    end else begin
      unique case (tx_state_q)
        SSA_TX_IDLE: begin
          // A high phase already in progress is not a full one
          if (!pin_lvl[PIN_TXCLK]) begin
            tx_state_q <= SSA_TX_ARM; // RULE9
          end
        end
        SSA_TX_ARM: begin
          if (tx_rise) begin
            tx_state_q <= SSA_TX_RUN; // RULE9
          end
        end
        SSA_TX_RUN: begin
          if (tx_fall) begin
            if (tx_idx_q == LAST_BIT) begin
              tx_data_o <= tx_next_q[0]; // RULE6 RULE9 RULE21
              tx_sr_q   <= tx_next_q >> 1;
              tx_idx_q  <= '0;
            end else begin
              tx_data_o <= tx_sr_q[0]; // RULE6 RULE21
              tx_sr_q   <= tx_sr_q >> 1;
              tx_idx_q  <= tx_idx_q + 3'h1;
            end
          end
        end
      endcase
      if (tx_load) begin
        tx_next_q <= txv_q[DEPTH-1] ? txf_q[DEPTH-1] : fill; // RULE5 RULE7 RULE10
      end
    end
  end

  // Underrun flag: set wins over the status-read clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      underrun_q <= 1'b0;
    end else if (tx_load && !txv_q[DEPTH-1]) begin
      underrun_q <= 1'b1; // RULE7
    end else if (rd_status) begin
      underrun_q <= 1'b0;
    end
  end

  // Receive shifter and character sync
  ssa_rx_state_t rx_state_q;
  logic [7:0]    rx_sr_q;
  logic [7:0]    rx_sr_d;
  logic [2:0]    rx_cnt_q;
  logic          rx_rise;
  logic          rx_push;
  logic          char_done;
  logic          ext_mode;
  assign rx_rise   = pin_rise[PIN_RXCLK];
  assign rx_sr_d   = {pin_lvl[PIN_RXD], rx_sr_q[7:1]}; // RULE21
  assign char_done = rx_rise && (rx_cnt_q == LAST_BIT);
  assign ext_mode  = ctl3_q[C3_EXT_SYNC];
  assign rx_push   = char_done && (rx_state_q == SSA_RX_SYNCED) &&
                     !(ctl1_q[C1_STRIP] && !ext_mode && rx_sr_d == sync_code_q); // RULE15

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || rx_hold || ctl1_q[C1_CLR_SYNC] || (ext_mode && !carrier)) begin
      rx_state_q <= SSA_RX_HUNT;
      rx_sr_q    <= FILL_ONES;
      rx_cnt_q   <= '0;
    end else if (rx_rise) begin
      rx_sr_q  <= rx_sr_d;
      rx_cnt_q <= rx_cnt_q + 3'h1;
      unique case (rx_state_q)
        SSA_RX_HUNT: begin
          if (ext_mode) begin
            rx_state_q <= SSA_RX_SYNCED; // RULE12
            rx_sr_q    <= {pin_lvl[PIN_RXD], FILL_ONES[7:1]};
            rx_cnt_q   <= 3'h1;
          end else if (rx_sr_d == sync_code_q) begin
            rx_state_q <= ctl3_q[C3_ONE_SYNC] ? SSA_RX_SYNCED : SSA_RX_SECOND; // RULE13
            rx_cnt_q   <= '0;
          end
        end
        SSA_RX_SECOND: begin
          if (rx_cnt_q == LAST_BIT) begin
            rx_state_q <= (rx_sr_d == sync_code_q) ? SSA_RX_SYNCED : SSA_RX_HUNT; // RULE14
          end
        end
        SSA_RX_SYNCED: begin
        end
      endcase
    end
  end

  // Receive FIFO: push into slot 0, pop slot DEPTH-1 on a data read
  logic [7:0]       rxf_q [DEPTH];
  logic [7:0]       rxf_d [DEPTH];
  logic [DEPTH-1:0] rxv_q;
  logic [DEPTH-1:0] rxv_d;
  logic             rda;
  logic             overrun_q;
  logic             ovr_seen_q;
  assign rda = two_byte ? rxv_q[DEPTH-1] & rxv_q[DEPTH-2] : rxv_q[DEPTH-1]; // RULE4 RULE15

  always_comb begin
    rxf_d = rxf_q;
    rxv_d = rxv_q;
    if (rd_data) begin
      rxv_d[DEPTH-1] = 1'b0;
    end
    for (int i = DEPTH - 1; i > 0; i--) begin
      if (!rxv_d[i] && rxv_d[i-1]) begin
        rxf_d[i]   = rxf_d[i-1];
        rxv_d[i]   = 1'b1;
        rxv_d[i-1] = 1'b0;
      end
    end
    if (rx_push) begin
      rxf_d[0] = rx_sr_d; // RULE12 RULE15
      rxv_d[0] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || rx_hold) begin
      rxv_q <= '0;
    end else begin
      rxv_q <= rxv_d;
    end
    rxf_q <= rxf_d;
  end

  // Overrun clears only after status then data read; a new overrun wins
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      overrun_q  <= 1'b0;
      ovr_seen_q <= 1'b0;
    end else if (rx_push && rxv_q[0] && !(rxv_q[1] == 1'b0)) begin
      overrun_q  <= 1'b1;
      ovr_seen_q <= 1'b0;
    end else begin
      if (rd_status && overrun_q) begin
        ovr_seen_q <= 1'b1;
      end
      if (rd_data && ovr_seen_q) begin
        overrun_q  <= 1'b0;
        ovr_seen_q <= 1'b0;
      end
    end
  end

  always_comb begin
    status              = REG_RESET;
    status[ST_RDA]      = rda;
    status[ST_TX_FIFO_SPACE_FLAG]     = tx_fifo_space_flag; // RULE2
    status[ST_DCD]      = carrier;
    status[ST_SYNC]     = (rx_state_q == SSA_RX_SYNCED);
    status[ST_UNDERRUN] = underrun_q;
    status[ST_OVERRUN]  = overrun_q;
  end

  // Read data settle while waitrequest is high, stand in the accept cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= {24'h00_0000,
                  (avs_address_i == ADDR_DATA) ? rxf_q[DEPTH-1] : status}; // RULE1 RULE20
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      terminal_ready_n_o <= 1'b1; // RULE16
      periph_ctl_two_o   <= 1'b0;
    end else begin
      terminal_ready_n_o <= ~ctl2_q[C2_PC_ONE]; // RULE18
      periph_ctl_two_o   <= ctl2_q[C2_PC_TWO];
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

  AST_TX_HOLD_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tx_hold |=> tx_data_o) else $error("Serial output not idle in hold"); // RULE16

  AST_TX_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(tx_hold) |=> (txv_q == '0)) else $error("FIFO not emptied by hold"); // RULE11

  AST_TX_FIFO_SPACE_FLAG_INHIBIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tx_hold |-> !status[ST_TX_FIFO_SPACE_FLAG]) else $error("Space flag shown during hold"); // RULE11

  AST_HW_RESET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hw_rst |=> ctl1_q[C1_TX_HOLD] && ctl1_q[C1_RX_HOLD] && !ctl2_q[C2_EIE]
              && !ctl3_q[C3_EXT_SYNC]) else $error("Pin reset bits wrong"); // RULE19

  AST_FIFO_ADVANCE: assert property (@(posedge sys_clk_i) disable iff (rst_i || tx_hold)
    txv_q[0] && !txv_q[1] && !tx_push |=> txv_q[1]) else $error("FIFO did not advance"); // RULE3

  AST_FILL_ON_EMPTY: assert property (@(posedge sys_clk_i) disable iff (rst_i || tx_hold)
    tx_load && !txv_q[DEPTH-1] |=> tx_next_q == $past(fill)) else $error("Bad fill"); // RULE7

  AST_LSB_FIRST: assert property (@(posedge sys_clk_i) disable iff (rst_i || tx_hold)
    tx_fall && tx_state_q == SSA_TX_RUN && tx_idx_q == LAST_BIT
    |=> tx_data_o == $past(tx_next_q[0])) else $error("First bit not LSB"); // RULE6

  AST_NO_PUSH_HUNT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rx_state_q != SSA_RX_SYNCED |-> !rx_push) else $error("Pushed before sync"); // RULE13

  AST_WAIT_ONE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (avs_read_i || avs_write_i) && wait_q |=> !wait_q ##1 wait_q)
    else $error("Waitrequest not one cycle low"); // RULE1

endmodule : ssa_top

// file: tb/ssa_codec_model.sv
// Behavioural codec on the serial side: free-running bit clock, streams both ways.
// Assumes the adapter changes its output on the falling clock and samples on the rise.
`timescale 1ns/10ps
module ssa_codec_model (
  input  wire logic tx_data_i,
  output logic      link_clk_o,
  output logic      rx_data_o,
  output logic      carrier_detect_n_o
);
  logic cap[$];
  logic bits[$];

  // Codec clock is timer driven and runs free; odd offset keeps it off the system phase
  initial begin
    link_clk_o         = 1'h0;
    rx_data_o          = 1'h1;
    carrier_detect_n_o = 1'h1;
    #13;
    forever #40 link_clk_o = ~link_clk_o;
  end

  always @(posedge link_clk_o) begin
    cap.push_back(tx_data_i);
  end

  // Idle line toggles, so a stale level never reads as a valid bit
  always @(negedge link_clk_o) begin
    if (bits.size() > 0) begin
      carrier_detect_n_o <= 1'h0;
      rx_data_o          <= bits.pop_front();
    end else begin
      carrier_detect_n_o <= 1'h1;
      rx_data_o          <= ~rx_data_o;
    end
  end

  task automatic push_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      bits.push_back(b[i]);
    end
  endtask : push_byte
endmodule : ssa_codec_model

// file: tb/testbench.sv
// Self-checking bench for the serial byte adapter: Avalon master tasks and scenarios.
// Assumes the codec model on the far side and tied transmit and receive clocks.
`timescale 1ns/10ps
module testbench;
  import ssa_pkg::*;

  logic        sys_clk_i;
  logic        rst_i;
  logic [0:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        hw_reset_n_i;
  logic        link_clk;
  logic        rx_data;
  logic        carrier_n;
  logic        tx_data_o;
  logic        terminal_ready_n_o;
  logic        periph_ctl_two_o;
  logic [31:0] rd;
  logic [7:0]  holds;
  int          n_fail;
  int          checks_done;

  ssa_top #(.DEPTH(3)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .hw_reset_n_i(hw_reset_n_i),
    .tx_clk_i(link_clk), .rx_clk_i(link_clk), .rx_data_i(rx_data),
    .carrier_detect_n_i(carrier_n), .tx_data_o(tx_data_o),
    .terminal_ready_n_o(terminal_ready_n_o), .periph_ctl_two_o(periph_ctl_two_o)
  );

  ssa_codec_model codec (
    .tx_data_i(tx_data_o), .link_clk_o(link_clk), .rx_data_o(rx_data),
    .carrier_detect_n_o(carrier_n)
  );

  initial begin
    sys_clk_i = 1'h0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [7:0] bv(input int i);
    return 8'h01 << i;
  endfunction : bv

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic hang(input string msg);
    n_fail++;
    $display("unexpected at %0t: %s timed out", $time, msg);
    results();
  endtask : hang

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic a, input logic wr, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i    <= a;
    avs_read_i       <= ~wr;
    avs_write_i      <= wr;
    avs_writedata_i  <= {24'h5A_5A5A, d};
    avs_byteenable_i <= be;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 20);
    rd = avs_readdata_o;
    avs_read_i  <= 1'h0;
    avs_write_i <= 1'h0;
    if (avs_waitrequest_o !== 1'h0) begin
      hang("bus");
    end
  endtask : bus

  task automatic rr(input logic a);
    bus(a, 1'h0, 8'h00, 4'hF);
  endtask : rr

  task automatic wr(input logic a, input logic [7:0] d);
    bus(a, 1'h1, d, 4'h1);
  endtask : wr

  task automatic wsel(input logic [1:0] s, input logic [7:0] v);
    wr(ADDR_CTL_STAT, holds | {s, 6'h00});
    wr(ADDR_DATA, v);
  endtask : wsel

  task automatic wait_rda();
    int n;
    n = 0;
    do begin
      rr(ADDR_CTL_STAT);
      n++;
    end while (rd[ST_RDA] !== 1'h1 && n < 1000);
    if (rd[ST_RDA] !== 1'h1) begin
      hang("receive");
    end
  endtask : wait_rda

  // Wire bits from the first zero on; bit k of exp is the k-th bit sent
  task automatic tx_expect(input logic [31:0] exp, input int nb, input string msg);
    int f;
    int s;
    int n;
    logic [31:0] seen;
    f = -1;
    s = 0;
    n = 0;
    seen = 32'h0000_0000;
    while ((f < 0 || codec.cap.size() < f + 8 * nb) && n < 4000) begin
      @(posedge sys_clk_i);
      n++;
      while (f < 0 && s < codec.cap.size()) begin
        if (codec.cap[s] === 1'h0) begin
          f = s;
        end
        s++;
      end
    end
    if (n >= 4000) begin
      hang(msg);
    end
    for (int k = 0; k < 8 * nb; k++) begin
      seen[k] = codec.cap[f + k];
    end
    check(seen, exp, msg);
  endtask : tx_expect

  task automatic rx_flush();
    holds = holds | bv(C1_RX_HOLD);
    wr(ADDR_CTL_STAT, holds | bv(C1_CLR_SYNC));
    repeat (3) rr(ADDR_DATA);
  endtask : rx_flush

  task automatic t_regs();
    wsel(SEL_CTL2, bv(C2_PC_ONE) | bv(C2_PC_TWO));
    repeat (2) @(posedge sys_clk_i);
    check(32'(terminal_ready_n_o), 32'(1'h0), "encode select");
    check(32'(periph_ctl_two_o), 32'(1'h1), "pc two");
    bus(ADDR_DATA, 1'h1, 8'h00, 4'h0);
    repeat (2) @(posedge sys_clk_i);
    check(32'(terminal_ready_n_o), 32'(1'h0), "masked write ignored");
    rr(ADDR_CTL_STAT);
    check({24'h00_0000, rd[7:6], 4'h0, rd[1:0]}, 32'h0000_0000, "status not control");
    @(posedge sys_clk_i);
    hw_reset_n_i <= 1'h0;
    repeat (10) @(posedge sys_clk_i);
    check(32'(terminal_ready_n_o), 32'(1'h1), "pc one cleared");
    wsel(SEL_CTL2, bv(C2_PC_ONE) | bv(C2_PC_TWO));
    repeat (2) @(posedge sys_clk_i);
    check(32'(periph_ctl_two_o), 32'(1'h0), "locked during reset");
    hw_reset_n_i <= 1'h1;
    repeat (10) @(posedge sys_clk_i);
    rr(ADDR_CTL_STAT);
    check(32'(rd[ST_TX_FIFO_SPACE_FLAG]), 32'(1'h0), "space flag inhibited");
    $display("test regs done");
  endtask : t_regs

  task automatic t_tx_data();
    wsel(SEL_TXDATA, 8'h36);
    wr(ADDR_DATA, 8'hC6);
    wr(ADDR_DATA, 8'h4E);
    wr(ADDR_DATA, 8'h81);
    rr(ADDR_CTL_STAT);
    check(32'(rd[ST_TX_FIFO_SPACE_FLAG]), 32'(1'h0), "flag held while holding");
    codec.cap.delete();
    holds = bv(C1_RX_HOLD);
    wr(ADDR_CTL_STAT, holds | {SEL_TXDATA, 6'h00});
    tx_expect(32'hFF4E_C636, 4, "three deep then ones fill");
    rr(ADDR_CTL_STAT);
    check(32'(rd[ST_TX_FIFO_SPACE_FLAG]), 32'(1'h1), "space flag");
    $display("test tx data done");
  endtask : t_tx_data

  task automatic t_tx_fill();
    holds = bv(C1_RX_HOLD) | bv(C1_TX_HOLD);
    wsel(SEL_SYNC, 8'h7E);
    rr(ADDR_CTL_STAT);
    check(32'(rd[ST_TX_FIFO_SPACE_FLAG]), 32'(1'h0), "hold clears flag");
    wsel(SEL_CTL3, bv(C3_UF_SYNC));
    repeat (20) @(posedge sys_clk_i);
    codec.cap.delete();
    holds = bv(C1_RX_HOLD);
    wr(ADDR_CTL_STAT, holds);
    tx_expect(32'h0000_7E7E, 2, "sync fill at start");
    wsel(SEL_CTL2, bv(C2_TWO_BYTE));
    wsel(SEL_TXDATA, 8'h5A);
    wr(ADDR_DATA, 8'hA5);
    rr(ADDR_CTL_STAT);
    check(32'(rd[ST_TX_FIFO_SPACE_FLAG]), 32'(1'h0), "two-byte flag");
    check(32'(rd[ST_UNDERRUN]), 32'(1'h1), "underrun");
    wsel(SEL_CTL2, REG_RESET);
    rr(ADDR_CTL_STAT);
    check(32'(rd[ST_TX_FIFO_SPACE_FLAG]), 32'(1'h1), "one-byte flag");
    holds = holds | bv(C1_TX_HOLD);
    wr(ADDR_CTL_STAT, holds);
    $display("test tx fill done");
  endtask : t_tx_fill

  task automatic t_rx_ext();
    logic [7:0] exp[3];
    exp = '{8'hA5, 8'h3C, 8'h81};
    wsel(SEL_CTL3, bv(C3_EXT_SYNC));
    holds = bv(C1_TX_HOLD);
    wr(ADDR_CTL_STAT, holds);
    repeat (20) @(posedge sys_clk_i);
    for (int i = 0; i < 3; i++) begin
      codec.push_byte(exp[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wait_rda();
      rr(ADDR_DATA);
      check(32'(rd[7:0]), 32'(exp[i]), "external sync byte");
    end
    $display("test rx external done");
  endtask : t_rx_ext

  task automatic t_rx_one();
    rx_flush();
    wsel(SEL_CTL3, bv(C3_ONE_SYNC));
    holds = bv(C1_TX_HOLD);
    wr(ADDR_CTL_STAT, holds);
    repeat (300) @(posedge sys_clk_i);
    rr(ADDR_CTL_STAT);
    check(32'(rd[ST_RDA]), 32'(1'h0), "nothing before sync");
    codec.push_byte(8'h7E);
    codec.push_byte(8'hC3);
    wait_rda();
    check(32'(rd[ST_SYNC]), 32'(1'h1), "synced status");
    rr(ADDR_DATA);
    check(32'(rd[7:0]), 32'(8'hC3), "first byte after one sync");
    $display("test rx one sync done");
  endtask : t_rx_one

  task automatic t_rx_two();
    rx_flush();
    wsel(SEL_CTL3, REG_RESET);
    holds = bv(C1_TX_HOLD);
    wr(ADDR_CTL_STAT, holds);
    repeat (20) @(posedge sys_clk_i);
    codec.push_byte(8'h7E);
    codec.push_byte(8'h12);
    codec.push_byte(8'h7E);
    codec.push_byte(8'h7E);
    codec.push_byte(8'h9A);
    wait_rda();
    rr(ADDR_DATA);
    check(32'(rd[7:0]), 32'(8'h9A), "first byte after two syncs");
    $display("test rx two sync done");
  endtask : t_rx_two

  initial begin
    rst_i            = 1'h1;
    avs_address_i    = ADDR_CTL_STAT;
    avs_read_i       = 1'h0;
    avs_write_i      = 1'h0;
    avs_writedata_i  = 32'h0000_0000;
    avs_byteenable_i = 4'h0;
    hw_reset_n_i     = 1'h1;
    rd               = 32'h0000_0000;
    holds            = CTL1_RESET;
    n_fail           = 0;
    checks_done      = 0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    check(32'(tx_data_o), 32'(1'h1), "line quiet in reset");
    check(32'(avs_waitrequest_o), 32'(1'h1), "bus quiet in reset");
    check(32'(terminal_ready_n_o), 32'(1'h1), "ready quiet in reset");
    @(posedge sys_clk_i);
    rst_i <= 1'h0;
    t_regs();
    t_tx_data();
    t_tx_fill();
    t_rx_ext();
    t_rx_one();
    t_rx_two();
    results();
  end
endmodule : testbench
